/* File: core/acc_regs.svh */
// Purpose: named constants for the three-wire accelerometer controller
// Assumes: 125 MHz system clock, APB register access
// Notes: offsets are byte addresses on a 32-bit APB bus
// Contract
// - write one to the serial-mode bit of format register 0x31 before sampling
// - format bits: selftest D7, serial mode D6, polarity, zero, resolution, justify, range
// - configure 10-bit samples, right-justified, plus or minus 2 g range
// - program a 400 Hz output data rate during initialisation
// - poll source register 0x30; read axes only when sample-ready is set
// - fetch all axes in one six-byte burst from 0x32 to 0x37
// - axis value is two's complement, low byte first then high byte
// - clock idles high; data changes on falling, sampled on rising edge
// - serial timing derives from a 10 MHz base rate
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
// timing
`define ACC_CLK_MHZ 125
`define ACC_BASE_NS 100
`define ACC_HALF_CYC (`ACC_CLK_MHZ * `ACC_BASE_NS / 1000)
// apb register offsets
`define ACC_OFF_CTRL 8'h00
`define ACC_OFF_STATE 8'h04
`define ACC_OFF_ISTAT 8'h08
`define ACC_OFF_ICLR 8'h0c
`define ACC_OFF_IEN 8'h10
`define ACC_OFF_AXX 8'h20
`define ACC_OFF_AXY 8'h24
`define ACC_OFF_AXZ 8'h28
// sensor register addresses and values
`define ACC_REG_INTSRC 6'h30
`define ACC_REG_FORMAT 6'h31
`define ACC_REG_DATA0 6'h32
`define ACC_FMT_VALUE 8'h40
`define ACC_SELFTEST_POS 7
`define ACC_SERIAL_POS 6
`define ACC_FULLRES_POS 3
`define ACC_JUSTIFY_POS 2
`define ACC_READY_POS 7
// command byte and transfer lengths
`define ACC_CMD_RD 2'h2
`define ACC_CMD_RDMB 2'h3
`define ACC_CMD_WR 2'h0
`define ACC_CMD_BITS 6'h08
`define ACC_XFER_SHORT 6'h10
`define ACC_XFER_BURST 6'h38
`define ACC_IRQ_W 2
`endif

/* File: core/acc_pkg.sv */
// Purpose: types shared by the accelerometer controller files
// Assumes: nothing
// Notes: one-hot state codes
package acc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SHIFT = 3'h2,
    ST_GAP = 3'h4
  } acc_state_type;
  typedef enum logic [4:0] {
    SQ_FMT = 5'h01,
    SQ_RATE = 5'h02,
    SQ_PWR = 5'h04,
    SQ_POLL = 5'h08,
    SQ_READ = 5'h10
  } acc_step_type;
endpackage

/* File: core/acc_mem_if.sv */
// Purpose: carrier between controller and sample store
// Assumes: single clock
// Notes: read data lags read address by one clock
`timescale 1ns/100ps
interface acc_mem_if #(parameter int DW = 16, parameter int AW = 2);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: core/acc_sample_mem.sv */
// Purpose: holds the latest axis words
// Assumes: one write and one read port
// Notes: read data registered
`timescale 1ns/100ps
module acc_sample_mem #(
  parameter int DW = 16,
  parameter int AW = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // access ports
  acc_mem_if.store mem
);
  logic [DW-1:0] word_q [2**AW];

  // storage write
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        word_q[i] <= '0;
      end
    end else if (mem.wr_en) begin
      word_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  // registered read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem.rd_data <= '0;
    end else begin
      mem.rd_data <= word_q[mem.rd_addr];
    end
  end
endmodule

/* File: core/acc_spi3_ctrl.sv */
// Purpose: three-wire accelerometer controller with apb registers
// Assumes: 125 MHz clock, sensor answers in three-wire mode after setup
// Notes: serial clock made by divider, returned data synchronised
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_spi3_ctrl #(
  parameter logic [5:0] RATE_ADDR = 6'h2c,
  parameter logic [7:0] RATE_CODE = 8'h0c,
  parameter logic [5:0] PWR_ADDR = 6'h2d,
  parameter logic [7:0] PWR_CODE = 8'h08
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // interrupt
  output logic IRQ_O,
  // serial link
  output logic CS_N_O,
  output logic SCLK_O,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_O
);

  localparam logic [7:0] HALF_M1 = 8'(`ACC_HALF_CYC - 1);

  acc_pkg::acc_state_type state_q;
  acc_pkg::acc_step_type step_q;
  logic [7:0] hc_q;
  logic tick, cs_n_q, sclk_q, sdo_q, oe_q, rd_q;
  logic [15:0] tx_q, rx_q;
  logic [5:0] cnt_q, total_q, nxt_cnt;
  logic sdio_s1_q, sdio_s2_q;
  logic [15:0] next_tx;
  logic [5:0] next_total;
  logic next_rd;
  logic gap_end;
  logic run_q;
  logic [`ACC_IRQ_W-1:0] ev;
  logic [`ACC_IRQ_W-1:0] istat_q;
  logic [`ACC_IRQ_W-1:0] istat_d;
  logic [`ACC_IRQ_W-1:0] ien_q;
  logic [`ACC_IRQ_W-1:0] iclr;
  logic irq_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_val;
  logic wr_fire;
  logic mem_wr_q;
  logic [1:0] mem_wa_q;
  logic [15:0] mem_wd_q;

  acc_mem_if #(.DW(16), .AW(2)) mem ();

  acc_sample_mem #(.DW(16), .AW(2)) u_store (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .mem(mem.store)
  );

  // mapped offsets of the register file
  function automatic logic acc_mapped(input logic [7:0] a);
    return a == `ACC_OFF_CTRL || a == `ACC_OFF_STATE || a == `ACC_OFF_ISTAT ||
      a == `ACC_OFF_ICLR || a == `ACC_OFF_IEN || a == `ACC_OFF_AXX ||
      a == `ACC_OFF_AXY || a == `ACC_OFF_AXZ;
  endfunction

  // two-flop synchroniser on the returned data line
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sdio_s1_q <= 1'b0;
      sdio_s2_q <= 1'b0;
    end else begin
      sdio_s1_q <= SDIO_I;
      sdio_s2_q <= sdio_s1_q;
    end
  end

  // half-period divider from the base rate
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hc_q <= 8'h00;
    end else if (state_q == acc_pkg::ST_IDLE || tick) begin
      hc_q <= 8'h00;
    end else begin
      hc_q <= hc_q + 8'h01;
    end
  end

  assign tick = hc_q == HALF_M1;
  assign nxt_cnt = cnt_q + 6'h01;
  assign gap_end = state_q == acc_pkg::ST_GAP && tick && cs_n_q;

  // command and length for the current sequence step
  always_comb begin
    next_tx = 16'h0000;
    next_total = `ACC_XFER_SHORT;
    next_rd = 1'b0;
    unique case (step_q)
      acc_pkg::SQ_FMT: begin
        next_tx = {`ACC_CMD_WR, `ACC_REG_FORMAT, `ACC_FMT_VALUE};
      end
      acc_pkg::SQ_RATE: begin
        next_tx = {`ACC_CMD_WR, RATE_ADDR, RATE_CODE};
      end
      acc_pkg::SQ_PWR: begin
        next_tx = {`ACC_CMD_WR, PWR_ADDR, PWR_CODE};
      end
      acc_pkg::SQ_POLL: begin
        next_tx = {`ACC_CMD_RD, `ACC_REG_INTSRC, 8'h00};
        next_rd = 1'b1;
      end
      acc_pkg::SQ_READ: begin
        next_tx = {`ACC_CMD_RDMB, `ACC_REG_DATA0, 8'h00};
        next_total = `ACC_XFER_BURST;
        next_rd = 1'b1;
      end
    endcase
  end

  // bit engine: clock, select, data out and enable
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q <= acc_pkg::ST_IDLE;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b1;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      tx_q <= 16'h0000;
      cnt_q <= 6'h00;
      total_q <= 6'h00;
    end else begin
      unique case (state_q)
        acc_pkg::ST_IDLE: begin
          if (run_q) begin
            state_q <= acc_pkg::ST_SHIFT;
            cs_n_q <= 1'b0;
            tx_q <= next_tx;
            total_q <= next_total;
            rd_q <= next_rd;
            cnt_q <= 6'h00;
          end
        end
        acc_pkg::ST_SHIFT: begin
          if (tick && sclk_q) begin
            // falling edge: present the next bit
            sclk_q <= 1'b0;
            sdo_q <= tx_q[15];
            tx_q <= {tx_q[14:0], 1'b0};
            oe_q <= !rd_q || cnt_q < `ACC_CMD_BITS;
          end else if (tick) begin
            // rising edge: the sensor samples, we capture
            sclk_q <= 1'b1;
            cnt_q <= nxt_cnt;
            if (nxt_cnt == total_q) begin
              state_q <= acc_pkg::ST_GAP;
            end
          end
        end
        acc_pkg::ST_GAP: begin
          if (tick && !cs_n_q) begin
            // last bit held a half period before deselect
            cs_n_q <= 1'b1;
            oe_q <= 1'b0;
          end else if (tick) begin
            state_q <= acc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // capture returned bits on the rising edge
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_q <= 16'h0000;
    end else if (state_q == acc_pkg::ST_SHIFT && tick && !sclk_q && rd_q &&
                 cnt_q >= `ACC_CMD_BITS) begin
      rx_q <= {rx_q[14:0], sdio_s2_q};
    end
  end

  // axis word assembly, low byte first
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mem_wr_q <= 1'b0;
      mem_wa_q <= 2'h0;
      mem_wd_q <= 16'h0000;
    end else begin
      mem_wr_q <= 1'b0;
      if (state_q == acc_pkg::ST_SHIFT && tick && !sclk_q &&
          step_q == acc_pkg::SQ_READ && nxt_cnt[3:0] == 4'h8 &&
          nxt_cnt > `ACC_CMD_BITS) begin
        mem_wr_q <= 1'b1;
        mem_wa_q <= nxt_cnt[5:4] - 2'h1;
        mem_wd_q <= {rx_q[6:0], sdio_s2_q, rx_q[14:7]};
      end
    end
  end

  assign mem.wr_en = mem_wr_q;
  assign mem.wr_addr = mem_wa_q;
  assign mem.wr_data = mem_wd_q;
  assign mem.rd_addr = PADDR_I[3:2];

  // sequencer: setup writes, then poll and burst read
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      step_q <= acc_pkg::SQ_FMT;
    end else if (!run_q && state_q == acc_pkg::ST_IDLE) begin
      step_q <= acc_pkg::SQ_FMT;
    end else if (gap_end) begin
      unique case (step_q)
        acc_pkg::SQ_FMT: step_q <= acc_pkg::SQ_RATE;
        acc_pkg::SQ_RATE: step_q <= acc_pkg::SQ_PWR;
        acc_pkg::SQ_PWR: step_q <= acc_pkg::SQ_POLL;
        acc_pkg::SQ_POLL: begin
          if (rx_q[`ACC_READY_POS]) begin
            step_q <= acc_pkg::SQ_READ;
          end
        end
        acc_pkg::SQ_READ: step_q <= acc_pkg::SQ_POLL;
      endcase
    end
  end

  // events: bit0 sample stored, bit1 setup done
  assign ev = {gap_end && step_q == acc_pkg::SQ_PWR, gap_end && step_q == acc_pkg::SQ_READ};

  // apb access: one wait cycle, then ready
  assign wr_fire = PSEL_I && PENABLE_I && pready_q && PWRITE_I && acc_mapped(PADDR_I);
  assign iclr = (wr_fire && PADDR_I == `ACC_OFF_ICLR) ? PWDATA_I[`ACC_IRQ_W-1:0] : '0;

  // read data selection
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (PADDR_I)
      `ACC_OFF_CTRL: rd_val = {31'h0000_0000, run_q};
      `ACC_OFF_STATE: rd_val = {27'h000_0000, step_q};
      `ACC_OFF_ISTAT: rd_val = {30'h0000_0000, istat_q};
      `ACC_OFF_IEN: rd_val = {30'h0000_0000, ien_q};
      `ACC_OFF_AXX, `ACC_OFF_AXY, `ACC_OFF_AXZ: begin
        rd_val = {{16{mem.rd_data[15]}}, mem.rd_data};
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // apb answer registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (PSEL_I && PENABLE_I && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !acc_mapped(PADDR_I);
      prdata_q <= PWRITE_I ? 32'h0000_0000 : rd_val;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // control and enable registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      run_q <= 1'b0;
      ien_q <= '0;
    end else if (wr_fire && PADDR_I == `ACC_OFF_CTRL) begin
      run_q <= PWDATA_I[0];
    end else if (wr_fire && PADDR_I == `ACC_OFF_IEN) begin
      ien_q <= PWDATA_I[`ACC_IRQ_W-1:0];
    end
  end

  // sticky status, a new event wins over a clear
  assign istat_d = (istat_q & ~iclr) | ev;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      istat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q <= |(istat_d & ien_q);
    end
  end

  // outputs from flops
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign IRQ_O = irq_q;
  assign CS_N_O = cs_n_q;
  assign SCLK_O = sclk_q;
  assign SDIO_O = sdo_q;
  assign SDIO_OE_O = oe_q;

  // setup write carries format address and serial-mode bit
  fmt_write_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($fell(cs_n_q) && step_q == acc_pkg::SQ_FMT) |->
      tx_q[13:8] == `ACC_REG_FORMAT && tx_q[`ACC_SERIAL_POS])
    else $error("format write lacks serial-mode bit");
  // format layout, selftest off and 10-bit right-justified 2 g
  fmt_fields_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($fell(cs_n_q) && step_q == acc_pkg::SQ_FMT) |->
      !tx_q[`ACC_SELFTEST_POS] && !tx_q[5] && !tx_q[4])
    else $error("format upper bits wrong");
  fmt_range_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($fell(cs_n_q) && step_q == acc_pkg::SQ_FMT) |->
      !tx_q[`ACC_FULLRES_POS] && !tx_q[`ACC_JUSTIFY_POS] && tx_q[1:0] == 2'h0)
    else $error("format resolution or range wrong");
  rate_write_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($fell(cs_n_q) && step_q == acc_pkg::SQ_RATE) |->
      tx_q == {`ACC_CMD_WR, RATE_ADDR, RATE_CODE})
    else $error("rate write wrong");
  poll_gate_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($fell(cs_n_q) && step_q == acc_pkg::SQ_READ) |->
      $past(step_q, 2) == acc_pkg::SQ_POLL && rx_q[`ACC_READY_POS])
    else $error("burst read without ready flag");
  burst_cmd_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($fell(cs_n_q) && step_q == acc_pkg::SQ_READ) |->
      tx_q[15:8] == {`ACC_CMD_RDMB, `ACC_REG_DATA0} && total_q == `ACC_XFER_BURST)
    else $error("burst command or length wrong");
  word_order_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    mem_wr_q |-> mem_wd_q == {rx_q[7:0], rx_q[15:8]})
    else $error("axis byte order wrong");
  idle_high_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    ($changed(sdo_q) |-> $fell(sclk_q)) and (cs_n_q |-> sclk_q))
    else $error("clock mode violated");
  half_period_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    $changed(sclk_q) |-> $past(hc_q) == HALF_M1)
    else $error("serial half period wrong");
  bus_release_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (state_q == acc_pkg::ST_SHIFT && rd_q && cnt_q > `ACC_CMD_BITS) |-> !oe_q)
    else $error("data line driven during read");
  cmd_dir_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    $fell(cs_n_q) |-> tx_q[15] == rd_q && tx_q[14] == (total_q == `ACC_XFER_BURST))
    else $error("command byte direction bits wrong");
  apb_wait_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (PSEL_I && PENABLE_I && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("apb ready timing wrong");

endmodule

/* File: tb/acc_sensor_model.sv */
// Purpose: behavioural three-wire accelerometer on the shared data line
// Assumes: mode 3 framing, command byte first, auto-increment on multi-byte reads
// Notes: released line shows the inverse of its last driven value
`timescale 1ns/100ps
module acc_sensor_model #(
  parameter logic [5:0] RATE_ADDR = 6'h2c,
  parameter logic [5:0] PWR_ADDR = 6'h2d
) (
  // link from the controller
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  // sample source
  input wire logic ready_i,
  input wire logic [47:0] axes_i,
  // shared line and observations
  output logic line_o,
  output logic [7:0] fmt_o,
  output logic [7:0] rate_o,
  output logic [7:0] last_cmd_o,
  output int n_poll_o,
  output int n_burst_o,
  output int last_bits_o,
  output int viol_o
);
  logic [7:0] cmd_q;
  logic [7:0] wr_q;
  logic [7:0] b;
  logic drv_q;
  logic bit_q;
  logic last_q;
  logic fmt_seen_q;
  int bits_q;
  int idx;
  initial begin
    {fmt_o, rate_o, last_cmd_o, cmd_q, wr_q} = '0;
    {drv_q, bit_q, last_q, fmt_seen_q} = '0;
    {n_poll_o, n_burst_o, last_bits_o, viol_o, bits_q} = '0;
  end
  // register contents seen by reads
  function automatic logic [7:0] byte_at(input logic [5:0] a);
    if (a == 6'h30) return {ready_i, 7'h03};
    if (a >= 6'h32 && a <= 6'h37) return axes_i[8*(a-6'h32) +: 8];
    return 8'h5a;
  endfunction
  // shared line: conflict shows as unknown, released shows inverted history
  assign line_o = (sdo_oe_i && drv_q) ? 1'bx : sdo_oe_i ? sdo_i : drv_q ? bit_q : ~last_q;
  always @(sdo_i or sdo_oe_i or drv_q or bit_q) begin
    if (sdo_oe_i) last_q = sdo_i;
    else if (drv_q) last_q = bit_q;
  end
  // frame start, clock must idle high
  always @(negedge cs_n_i) begin
    bits_q = 0;
    if (sclk_i !== 1'b1) viol_o++;
  end
  // frame end: commit format and rate writes, log reads
  always @(posedge cs_n_i) begin
    drv_q = 1'b0;
    if (sclk_i !== 1'b1) viol_o++;
    if (!cmd_q[7] && bits_q == 16) begin
      if (cmd_q[5:0] == 6'h31) fmt_o = wr_q;
      if (cmd_q[5:0] == 6'h31 && wr_q[6]) fmt_seen_q = 1'b1;
      if (cmd_q[5:0] == RATE_ADDR) rate_o = wr_q;
    end
    if (cmd_q[7]) begin
      last_cmd_o = cmd_q;
      last_bits_o = bits_q;
      if (cmd_q[5:0] == 6'h30) n_poll_o++;
      else n_burst_o++;
      if (!fmt_seen_q) viol_o++;
    end
  end
  // sample on the rising edge
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (bits_q < 8 || !cmd_q[7]) begin
        if (sdo_oe_i !== 1'b1) viol_o++;
      end else if (sdo_oe_i !== 1'b0) viol_o++;
      if (bits_q < 8) cmd_q = {cmd_q[6:0], sdo_i};
      else if (!cmd_q[7]) wr_q = {wr_q[6:0], sdo_i};
      bits_q++;
    end
  end
  // present read data on the falling edge
  always @(negedge sclk_i) begin
    if (!cs_n_i && bits_q >= 8 && cmd_q[7]) begin
      idx = bits_q - 8;
      b = byte_at(cmd_q[6] ? 6'(int'(cmd_q[5:0]) + idx / 8) : cmd_q[5:0]);
      bit_q = b[3'(7 - idx % 8)];
      drv_q = 1'b1;
    end
  end
endmodule

/* File: tb/acc_spi3_ctrl_tb.sv */
// Purpose: self-checking bench for the three-wire accelerometer controller
// Assumes: apb master with one access per call, sensor model on the line
// Notes: expected values come from the sensor setup and sample bytes
`timescale 1ns/100ps
`include "acc_regs.svh"
module acc_spi3_ctrl_tb;
  localparam logic [5:0] RATE_ADDR = 6'h2c;
  localparam logic [7:0] RATE_400 = 8'h0c;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ready = 1'b0;
  logic [47:0] axes = {16'h8000, 16'h01ff, 16'hfe01};
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, irq, cs_n, sclk, sdo, sdo_oe, line, rerr;
  logic [7:0] fmt, rate, last_cmd;
  int n_poll, n_burst, last_bits, viol, base;
  int err_total = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  acc_spi3_ctrl #(.RATE_ADDR(RATE_ADDR), .RATE_CODE(RATE_400)) dut_u (
    .CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .CS_N_O(cs_n),
    .SCLK_O(sclk), .SDIO_I(line), .SDIO_O(sdo), .SDIO_OE_O(sdo_oe));
  acc_sensor_model #(.RATE_ADDR(RATE_ADDR)) sensor_u (
    .cs_n_i(cs_n), .sclk_i(sclk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .ready_i(ready),
    .axes_i(axes), .line_o(line), .fmt_o(fmt), .rate_o(rate), .last_cmd_o(last_cmd),
    .n_poll_o(n_poll), .n_burst_o(n_burst), .last_bits_o(last_bits), .viol_o(viol));
  // one comparison
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // apb transfer, held until pready is sampled high or 20 clocks pass
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) chk(32'h0, 32'h1, "no pready");
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, what);
    chk(32'(rerr), 32'h0, "slave error on mapped read");
  endtask
  // bounded wait on the sensor's transfer log
  task wait_xfer(input logic burst, input int n);
    int k;
    for (k = 0; k < 20000; k++) begin
      if ((burst ? n_burst : n_poll) >= n) break;
      @(posedge clk);
    end
    chk(32'((burst ? n_burst : n_poll) >= n), 32'h1, "transfer wait");
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(8 * 80000);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and unmapped access
    rd_chk(`ACC_OFF_ISTAT, 32'h0, "istat reset");
    rd_chk(`ACC_OFF_AXX, 32'h0, "axis x reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(rerr), 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    chk({cs_n, sclk, irq}, 32'h6, "idle link");
    $display("test reset done");
    // setup sequence then polling without data
    apb(1'b1, `ACC_OFF_IEN, 32'h2);
    apb(1'b1, `ACC_OFF_CTRL, 32'h1);
    wait_xfer(1'b0, 2);
    chk(32'(fmt), 32'h40, "format value");
    chk(32'(rate), 32'(RATE_400), "rate code");
    chk(32'(n_burst), 32'h0, "no burst before ready");
    chk(32'(last_cmd), 32'hb0, "poll command");
    chk(32'(last_bits), 32'd16, "poll length");
    rd_chk(`ACC_OFF_ISTAT, 32'h2, "setup done flag");
    rd_chk(`ACC_OFF_STATE, 32'h8, "poll step");
    chk(32'(irq), 32'h1, "setup irq");
    $display("test setup done");
    // one burst of sample bytes
    ready <= 1'b1;
    wait_xfer(1'b1, 1);
    ready <= 1'b0;
    chk(32'(last_cmd), 32'hf2, "burst command");
    chk(32'(last_bits), 32'd56, "burst length");
    rd_chk(`ACC_OFF_AXX, 32'hfffffe01, "axis x");
    rd_chk(`ACC_OFF_AXY, 32'h000001ff, "axis y");
    rd_chk(`ACC_OFF_AXZ, 32'hffff8000, "axis z");
    $display("test burst done");
    // interrupt clear, read-only status, mask
    apb(1'b1, `ACC_OFF_IEN, 32'h1);
    apb(1'b1, `ACC_OFF_ICLR, 32'h3);
    apb(1'b1, `ACC_OFF_ISTAT, 32'h3);
    rd_chk(`ACC_OFF_ISTAT, 32'h0, "status cleared");
    chk(32'(irq), 32'h0, "irq after clear");
    base = n_burst;
    ready <= 1'b1;
    wait_xfer(1'b1, base + 1);
    ready <= 1'b0;
    // sample event lands at the end of the frame gap
    repeat (32) @(posedge clk);
    rd_chk(`ACC_OFF_ISTAT, 32'h1, "sample flag");
    chk(32'(irq), 32'h1, "irq on sample");
    apb(1'b1, `ACC_OFF_IEN, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0, "irq masked");
    $display("test interrupt done");
    // stop after the current transfer
    apb(1'b1, `ACC_OFF_CTRL, 32'h0);
    repeat (1000) @(posedge clk);
    base = n_poll + n_burst;
    repeat (2000) @(posedge clk);
    chk(32'(n_poll + n_burst), 32'(base), "link stopped");
    chk({cs_n, sclk}, 32'h3, "stopped idle");
    rd_chk(`ACC_OFF_STATE, 32'h1, "step back to format");
    chk(32'(viol), 32'h0, "line protocol");
    $display("test stop done");
    test_done;
  end
endmodule
